// file: rtl/fxu_cfg.svh
// constants for the fp overflow/underflow exception unit
`ifndef FXU_CFG_SVH
`define FXU_CFG_SVH
`define FXU_OFF_STATUS 8'h00
`define FXU_OFF_CTRL 8'h04
`define FXU_OFF_FRAME 8'h08
`define FXU_OFF_IADDR 8'h0c
`define FXU_OFF_EA 8'h10
`define FXU_ST_EXC_OVERFLOW_FLAG 11
`define FXU_ST_EXC_UNDERFLOW_FLAG 10
`define FXU_ST_ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG 6
`define FXU_ST_ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG 5
`define FXU_FR_EARLY 0
`define FXU_FR_LATE 1
`define FXU_FR_POST 2
`define FXU_FR_EAV 3
`define FXU_FR_TMPV 4
`define FXU_CTRL_RST 7'h00
`define FXU_MIN_SGL 17'h1ff82
`define FXU_MIN_DBL 17'h1fc02
`define FXU_MIN_EXT 17'h1c002
`define FXU_MAX_SGL 17'h0007f
`define FXU_MAX_DBL 17'h003ff
`define FXU_MAX_EXT 17'h03fff
`endif

// file: rtl/fxu_pkg.sv
// types for the fp overflow/underflow exception unit
package fxu_pkg;
   typedef enum logic [1:0] {FXU_P_EXT = 2'h0, FXU_P_SGL = 2'h1, FXU_P_DBL = 2'h2} fxu_prec_t;
   typedef enum logic [1:0] {FXU_K_FPREG = 2'h0, FXU_K_MEM = 2'h1, FXU_K_INT = 2'h2} fxu_kind_t;
   typedef enum logic [5:0] {
      FXU_S_IDLE = 6'h01,
      FXU_S_UNDERFLOW_FLAG = 6'h02,
      FXU_S_RND = 6'h04,
      FXU_S_OVERFLOW_FLAG = 6'h08,
      FXU_S_WR = 6'h10,
      FXU_S_HOLD = 6'h20
   } fxu_state_t;
endpackage : fxu_pkg

// file: rtl/fxu_exc_unit.sv
// fp overflow/underflow detection, reporting and frame state
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "fxu_cfg.svh"
module fxu_exc_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [16:0] exp_i,
   input wire logic rnd_inc_i,
   input wire logic exp_wrap_i,
   input wire logic inex_i,
   input wire fxu_pkg::fxu_kind_t kind_i,
   input wire fxu_pkg::fxu_prec_t fmt_i,
   input wire logic forced_i,
   input wire fxu_pkg::fxu_prec_t op_prec_i,
   input wire logic move_out_i,
   input wire logic dep_move_i,
   input wire logic [31:0] op_addr_i,
   input wire logic [31:0] ea_i,
   input wire logic next_fp_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   output logic busy_o,
   output logic dest_we_o,
   output logic dest_undef_o,
   output logic dest_zero_o,
   output logic exc_req_o,
   output logic exc_post_o,
   output logic exc_underflow_flag_o,
   output logic exc_overflow_flag_o
);
   function automatic logic [16:0] prec_min(input fxu_pkg::fxu_prec_t p);
      unique case (p)
         fxu_pkg::FXU_P_SGL: prec_min = `FXU_MIN_SGL;
         fxu_pkg::FXU_P_DBL: prec_min = `FXU_MIN_DBL;
         default: prec_min = `FXU_MIN_EXT;
      endcase
   endfunction : prec_min

   function automatic logic [16:0] prec_max(input fxu_pkg::fxu_prec_t p);
      unique case (p)
         fxu_pkg::FXU_P_SGL: prec_max = `FXU_MAX_SGL;
         fxu_pkg::FXU_P_DBL: prec_max = `FXU_MAX_DBL;
         default: prec_max = `FXU_MAX_EXT;
      endcase
   endfunction : prec_max

   fxu_pkg::fxu_state_t state_q, state_d;
   fxu_pkg::fxu_kind_t kind_q, kind_d;
   fxu_pkg::fxu_prec_t prec_q, prec_d;
   logic [16:0] exp_q, exp_d;
   logic rinc_q, rinc_d, wrap_q, wrap_d, inex_q, inex_d;
   logic mout_q, mout_d, dep_q, dep_d;
   logic [31:0] opa_q, opa_d, opea_q, opea_d;
   logic underflow_flag_q, underflow_flag_d, overflow_flag_q, overflow_flag_d;
   logic exc_underflow_flag_q, exc_underflow_flag_d, exc_overflow_flag_q, exc_overflow_flag_d;
   logic accrued_exception_byte_underflow_flag_q, accrued_exception_byte_underflow_flag_d, accrued_exception_byte_overflow_flag_q, accrued_exception_byte_overflow_flag_d;
   logic [6:0] ctrl_q, ctrl_d;
   logic early_q, early_d, late_q, late_d, post_q, post_d, eav_q, eav_d, tmpv_q, tmpv_d;
   logic [31:0] iaddr_q, iaddr_d, ea_q, ea_d;
   logic [31:0] rdata_q, rdata_d;
   logic dwe_q, dwe_d, dund_q, dund_d, dzero_q, dzero_d;
   logic req_q, req_d, rpost_q, rpost_d, runfl_q, runfl_d, rovfl_q, rovfl_d;
   logic wr_st, wr_fr, exc, go_post;
   logic busy_q, busy_d;

   assign exc = underflow_flag_q | overflow_flag_q;
   // fp register destinations may defer; anything else cannot wait
   assign go_post = (kind_q != fxu_pkg::FXU_K_FPREG) | dep_q | mout_q;
   assign wr_st = we_i & (addr_i == `FXU_OFF_STATUS);
   assign wr_fr = we_i & (addr_i == `FXU_OFF_FRAME);

   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      prec_d = prec_q;
      exp_d = exp_q;
      rinc_d = rinc_q;
      wrap_d = wrap_q;
      inex_d = inex_q;
      mout_d = mout_q;
      dep_d = dep_q;
      opa_d = opa_q;
      opea_d = opea_q;
      underflow_flag_d = underflow_flag_q;
      overflow_flag_d = overflow_flag_q;
      iaddr_d = iaddr_q;
      ea_d = ea_q;
      ctrl_d = ctrl_q;
      dwe_d = 1'b0;
      dund_d = 1'b0;
      dzero_d = 1'b0;
      req_d = 1'b0;
      rpost_d = rpost_q;
      runfl_d = runfl_q;
      rovfl_d = rovfl_q;
      // software clears by writing ones; hardware set wins
      exc_underflow_flag_d = exc_underflow_flag_q & ~(wr_st & wdata_i[`FXU_ST_EXC_UNDERFLOW_FLAG]);
      exc_overflow_flag_d = exc_overflow_flag_q & ~(wr_st & wdata_i[`FXU_ST_EXC_OVERFLOW_FLAG]);
      accrued_exception_byte_underflow_flag_d = accrued_exception_byte_underflow_flag_q & ~(wr_st & wdata_i[`FXU_ST_ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG]);
      accrued_exception_byte_overflow_flag_d = accrued_exception_byte_overflow_flag_q & ~(wr_st & wdata_i[`FXU_ST_ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG]);
      early_d = early_q & ~(wr_fr & wdata_i[`FXU_FR_EARLY]);
      late_d = late_q & ~(wr_fr & wdata_i[`FXU_FR_LATE]);
      post_d = post_q;
      eav_d = eav_q;
      tmpv_d = tmpv_q;
      if (we_i && addr_i == `FXU_OFF_CTRL) begin
         ctrl_d = wdata_i[6:0];
      end
      unique case (state_q)
         fxu_pkg::FXU_S_IDLE: begin
            if (start_i) begin
               kind_d = kind_i;
               exp_d = exp_i;
               rinc_d = rnd_inc_i;
               wrap_d = exp_wrap_i;
               inex_d = inex_i;
               mout_d = move_out_i;
               dep_d = dep_move_i;
               opa_d = op_addr_i;
               opea_d = ea_i;
               if (forced_i) begin
                  prec_d = op_prec_i;
               end else if (kind_i == fxu_pkg::FXU_K_MEM) begin
                  prec_d = fmt_i;
               end else begin
                  prec_d = fxu_pkg::fxu_prec_t'(ctrl_q[1:0]);
               end
               state_d = fxu_pkg::FXU_S_UNDERFLOW_FLAG;
            end
         end
         fxu_pkg::FXU_S_UNDERFLOW_FLAG: begin
            // extended keeps a normal number at its minimum: strict compare there
            if (kind_q == fxu_pkg::FXU_K_INT) begin
               underflow_flag_d = 1'b0;
            end else if (prec_q == fxu_pkg::FXU_P_EXT) begin
               underflow_flag_d = $signed(exp_q) < $signed(prec_min(prec_q));
            end else begin
               underflow_flag_d = $signed(exp_q) <= $signed(prec_min(prec_q));
            end
            state_d = fxu_pkg::FXU_S_RND;
         end
         fxu_pkg::FXU_S_RND: begin
            exp_d = exp_q + {16'h0000, rinc_q};
            state_d = fxu_pkg::FXU_S_OVERFLOW_FLAG;
         end
         fxu_pkg::FXU_S_OVERFLOW_FLAG: begin
            overflow_flag_d = (kind_q != fxu_pkg::FXU_K_INT) &
                     (wrap_q | ($signed(exp_q) >= $signed(prec_max(prec_q))));
            state_d = fxu_pkg::FXU_S_WR;
         end
         fxu_pkg::FXU_S_WR: begin
            // an fp register keeps its old value even when the report is post
            dwe_d = ~exc | (kind_q != fxu_pkg::FXU_K_FPREG);
            dund_d = exc & (kind_q != fxu_pkg::FXU_K_FPREG);
            dzero_d = (kind_q == fxu_pkg::FXU_K_INT) & ~exc;
            exc_underflow_flag_d = exc_underflow_flag_d | underflow_flag_q;
            accrued_exception_byte_underflow_flag_d = accrued_exception_byte_underflow_flag_d | (underflow_flag_q & inex_q);
            exc_overflow_flag_d = exc_overflow_flag_d | overflow_flag_q;
            accrued_exception_byte_overflow_flag_d = accrued_exception_byte_overflow_flag_d | overflow_flag_q;
            state_d = fxu_pkg::FXU_S_IDLE;
            if (exc) begin
               runfl_d = underflow_flag_q;
               rovfl_d = overflow_flag_q;
               rpost_d = go_post;
               post_d = go_post;
               eav_d = mout_q;
               tmpv_d = ~wrap_q;
               iaddr_d = opa_q;
               ea_d = opea_q;
               if (go_post) begin
                  req_d = 1'b1;
                  late_d = 1'b1;
               end else begin
                  early_d = 1'b1;
                  state_d = fxu_pkg::FXU_S_HOLD;
               end
            end
         end
         fxu_pkg::FXU_S_HOLD: begin
            // held until the next fp instruction, then reported once
            if (next_fp_i) begin
               req_d = 1'b1;
               state_d = fxu_pkg::FXU_S_IDLE;
            end
         end
         default: state_d = fxu_pkg::FXU_S_IDLE;
      endcase
      busy_d = (state_d != fxu_pkg::FXU_S_IDLE);
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (re_i) begin
         unique case (addr_i)
            `FXU_OFF_STATUS: begin
               rdata_d[`FXU_ST_EXC_UNDERFLOW_FLAG] = exc_underflow_flag_q;
               rdata_d[`FXU_ST_EXC_OVERFLOW_FLAG] = exc_overflow_flag_q;
               rdata_d[`FXU_ST_ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG] = accrued_exception_byte_underflow_flag_q;
               rdata_d[`FXU_ST_ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG] = accrued_exception_byte_overflow_flag_q;
            end
            `FXU_OFF_CTRL: rdata_d[6:0] = ctrl_q;
            `FXU_OFF_FRAME: rdata_d[4:0] = {tmpv_q, eav_q, post_q, late_q, early_q};
            `FXU_OFF_IADDR: rdata_d = iaddr_q;
            `FXU_OFF_EA: rdata_d = ea_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= fxu_pkg::FXU_S_IDLE;
         kind_q <= fxu_pkg::FXU_K_FPREG;
         prec_q <= fxu_pkg::FXU_P_EXT;
         exp_q <= 17'h00000;
         {rinc_q, wrap_q, inex_q, mout_q, dep_q} <= 5'h00;
         opa_q <= 32'h0000_0000;
         opea_q <= 32'h0000_0000;
         {underflow_flag_q, overflow_flag_q} <= 2'h0;
         {exc_underflow_flag_q, exc_overflow_flag_q, accrued_exception_byte_underflow_flag_q, accrued_exception_byte_overflow_flag_q} <= 4'h0;
         ctrl_q <= `FXU_CTRL_RST;
         {early_q, late_q, post_q, eav_q, tmpv_q} <= 5'h00;
         iaddr_q <= 32'h0000_0000;
         ea_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         {dwe_q, dund_q, dzero_q} <= 3'h0;
         {req_q, rpost_q, runfl_q, rovfl_q} <= 4'h0;
         busy_q <= 1'b0;
      end else if (ce_i) begin
         state_q <= state_d;
         kind_q <= kind_d;
         prec_q <= prec_d;
         exp_q <= exp_d;
         {rinc_q, wrap_q, inex_q, mout_q, dep_q} <= {rinc_d, wrap_d, inex_d, mout_d, dep_d};
         opa_q <= opa_d;
         opea_q <= opea_d;
         {underflow_flag_q, overflow_flag_q} <= {underflow_flag_d, overflow_flag_d};
         {exc_underflow_flag_q, exc_overflow_flag_q, accrued_exception_byte_underflow_flag_q, accrued_exception_byte_overflow_flag_q} <= {exc_underflow_flag_d, exc_overflow_flag_d, accrued_exception_byte_underflow_flag_d, accrued_exception_byte_overflow_flag_d};
         ctrl_q <= ctrl_d;
         {early_q, late_q, post_q, eav_q, tmpv_q} <= {early_d, late_d, post_d, eav_d, tmpv_d};
         iaddr_q <= iaddr_d;
         ea_q <= ea_d;
         rdata_q <= rdata_d;
         {dwe_q, dund_q, dzero_q} <= {dwe_d, dund_d, dzero_d};
         {req_q, rpost_q, runfl_q, rovfl_q} <= {req_d, rpost_d, runfl_d, rovfl_d};
         busy_q <= busy_d;
      end
   end

   assign rdata_o = rdata_q;
   assign busy_o = busy_q;
   assign dest_we_o = dwe_q;
   assign dest_undef_o = dund_q;
   assign dest_zero_o = dzero_q;
   assign exc_req_o = req_q;
   assign exc_post_o = rpost_q;
   assign exc_underflow_flag_o = runfl_q;
   assign exc_overflow_flag_o = rovfl_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   a_single_min: assert property (state_q == fxu_pkg::FXU_S_UNDERFLOW_FLAG && kind_q != fxu_pkg::FXU_K_INT &&
      prec_q == fxu_pkg::FXU_P_SGL && exp_q == `FXU_MIN_SGL |=> underflow_flag_q) else $error("single minimum not tiny");
   a_ext_min_ok: assert property (state_q == fxu_pkg::FXU_S_UNDERFLOW_FLAG && prec_q == fxu_pkg::FXU_P_EXT &&
      exp_q == `FXU_MIN_EXT |=> !underflow_flag_q) else $error("extended minimum flagged");
   a_int_no_underflow_flag: assert property (state_q == fxu_pkg::FXU_S_UNDERFLOW_FLAG && kind_q == fxu_pkg::FXU_K_INT
      |=> !underflow_flag_q ##3 !req_q) else $error("integer destination raised underflow");
   a_check_order: assert property (state_q == fxu_pkg::FXU_S_UNDERFLOW_FLAG |=> state_q == fxu_pkg::FXU_S_RND
      ##1 state_q == fxu_pkg::FXU_S_OVERFLOW_FLAG ##1 state_q == fxu_pkg::FXU_S_WR) else $error("check order broken");
   a_underflow_flag_status: assert property (state_q == fxu_pkg::FXU_S_WR && underflow_flag_q |=> exc_underflow_flag_q)
      else $error("underflow status flag missing");
   a_accrued_underflow_flag: assert property (state_q == fxu_pkg::FXU_S_WR && underflow_flag_q && !accrued_exception_byte_underflow_flag_q &&
      !inex_q |=> !accrued_exception_byte_underflow_flag_q) else $error("accrued underflow without inexact");
   a_fpreg_kept: assert property (state_q == fxu_pkg::FXU_S_WR && exc &&
      kind_q == fxu_pkg::FXU_K_FPREG |=> !dest_we_o) else $error("fp register destination written");
   a_mem_post: assert property (state_q == fxu_pkg::FXU_S_WR && exc && kind_q != fxu_pkg::FXU_K_FPREG
      |=> exc_req_o && exc_post_o && dest_we_o && dest_undef_o) else $error("memory exception not post");
   a_dep_post: assert property (state_q == fxu_pkg::FXU_S_WR && exc && dep_q |=> exc_req_o && exc_post_o)
      else $error("dependent move not post");
   a_ea_valid: assert property (state_q == fxu_pkg::FXU_S_WR && exc |=> eav_q == $past(mout_q))
      else $error("effective address valid bit wrong");
   a_iaddr_load: assert property (state_q == fxu_pkg::FXU_S_WR && exc |=> iaddr_q == $past(opa_q))
      else $error("instruction address not captured");
   a_ea_capture: assert property (state_q == fxu_pkg::FXU_S_WR && exc && mout_q |=> ea_q == $past(opea_q))
      else $error("move-out effective address not captured");
   a_wrap_tmp: assert property (state_q == fxu_pkg::FXU_S_WR && exc && wrap_q |=> !tmpv_q)
      else $error("wrapped exponent left fields valid");
   a_hold_report: assert property (state_q == fxu_pkg::FXU_S_HOLD && next_fp_i |=> exc_req_o && !exc_post_o
      ##1 !exc_req_o) else $error("pending exception not reported once");
   a_one_report: assert property (exc_req_o |=> !exc_req_o) else $error("double report");

   c_underflow_flag_post: cover property (exc_req_o && exc_post_o && exc_underflow_flag_o);
   c_overflow_flag_pre: cover property (exc_req_o && !exc_post_o && exc_overflow_flag_o);
   c_int_zero: cover property (dest_zero_o);
   c_both: cover property (state_q == fxu_pkg::FXU_S_WR && underflow_flag_q && overflow_flag_q);
   c_pre_hold: cover property (state_q == fxu_pkg::FXU_S_HOLD && next_fp_i);
endmodule : fxu_exc_unit

// file: bench/fxu_exc_unit_test.sv
// self-checking bench for the fp overflow/underflow exception unit
`timescale 1ns/10ps
`include "fxu_cfg.svh"
module fxu_exc_unit_test;
   logic clk_i, rst_i, ce_i, start_i, rnd_inc_i, exp_wrap_i, inex_i, forced_i, move_out_i, dep_move_i;
   logic next_fp_i, we_i, re_i;
   logic [16:0] exp_i;
   fxu_pkg::fxu_kind_t kind_i;
   fxu_pkg::fxu_prec_t fmt_i, op_prec_i;
   logic [31:0] op_addr_i, ea_i, wdata_i, rdata_o, rv;
   logic [7:0] addr_i, ov;
   logic busy_o, dest_we_o, dest_undef_o, dest_zero_o, exc_req_o, exc_post_o, exc_underflow_flag_o, exc_overflow_flag_o;
   int mismatches, n_tests;

   fxu_exc_unit fxu_exc_unit_inst (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i), .exp_i(exp_i), .rnd_inc_i(rnd_inc_i),
      .exp_wrap_i(exp_wrap_i), .inex_i(inex_i), .kind_i(kind_i), .fmt_i(fmt_i), .forced_i(forced_i),
      .op_prec_i(op_prec_i), .move_out_i(move_out_i), .dep_move_i(dep_move_i), .op_addr_i(op_addr_i),
      .ea_i(ea_i), .next_fp_i(next_fp_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
      .rdata_o(rdata_o), .busy_o(busy_o), .dest_we_o(dest_we_o), .dest_undef_o(dest_undef_o),
      .dest_zero_o(dest_zero_o), .exc_req_o(exc_req_o), .exc_post_o(exc_post_o), .exc_underflow_flag_o(exc_underflow_flag_o),
      .exc_overflow_flag_o(exc_overflow_flag_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask : wr

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      rv = rdata_o;
   endtask : rd

   task automatic clr;
      wr(`FXU_OFF_STATUS, 32'hffffffff);
      wr(`FXU_OFF_FRAME, 32'hffffffff);
   endtask : clr

   // fl = {rnd_inc, wrap, inex}, mv = {move_out, dep_move}; outputs sampled in cycle 5
   task automatic op(input logic [16:0] e, input logic [2:0] fl, input fxu_pkg::fxu_kind_t k,
         input fxu_pkg::fxu_prec_t f, input logic [1:0] mv);
      @(posedge clk_i);
      start_i <= 1'b1;
      exp_i <= e;
      {rnd_inc_i, exp_wrap_i, inex_i} <= fl;
      kind_i <= k;
      fmt_i <= f;
      {move_out_i, dep_move_i} <= mv;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      ov = {dest_we_o, dest_undef_o, dest_zero_o, exc_req_o, exc_post_o, exc_underflow_flag_o, exc_overflow_flag_o, busy_o};
   endtask : op

   task automatic t_regs;
      rd(`FXU_OFF_STATUS);
      chk("status reset", rv, 32'h0);
      rd(`FXU_OFF_FRAME);
      chk("frame reset", rv, 32'h0);
      rd(`FXU_OFF_CTRL);
      chk("control reset", rv, 32'h0);
      wr(8'h20, 32'hffffffff);
      rd(8'h20);
      chk("unmapped", rv, 32'h0);
      // all control bits on, read back, then off: exceptions below run with control 0 except t_dep_overflow_flag, which sets 2 (double)
      wr(`FXU_OFF_CTRL, 32'h7f);
      rd(`FXU_OFF_CTRL);
      chk("control", rv, 32'h7f);
      wr(`FXU_OFF_CTRL, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_mem_underflow_flag;
      op(`FXU_MIN_SGL, 3'h0, fxu_pkg::FXU_K_MEM, fxu_pkg::FXU_P_SGL, 2'h2);
      chk("mem underflow_flag outputs", ov, 8'hdc);
      rd(`FXU_OFF_STATUS);
      chk("mem underflow_flag status", rv, 32'h400);
      rd(`FXU_OFF_FRAME);
      chk("mem underflow_flag frame", rv, 32'h1e);
      rd(`FXU_OFF_EA);
      chk("mem underflow_flag ea", rv, ea_i);
      rd(`FXU_OFF_IADDR);
      chk("iaddr", rv, op_addr_i);
      clr();
      $display("test mem underflow done");
   endtask : t_mem_underflow_flag

   task automatic t_pre_report;
      op(`FXU_MIN_EXT, 3'h0, fxu_pkg::FXU_K_FPREG, fxu_pkg::FXU_P_EXT, 2'h0);
      chk("ext min", ov & 8'hf1, 8'h80);
      op(`FXU_MIN_EXT - 17'h1, 3'h1, fxu_pkg::FXU_K_FPREG, fxu_pkg::FXU_P_EXT, 2'h0);
      chk("pre hold", ov & 8'hf1, 8'h01);
      rd(`FXU_OFF_FRAME);
      chk("pre frame", rv & 32'h7, 32'h1);
      rd(`FXU_OFF_STATUS);
      chk("pre status", rv, 32'h420);
      // a new start while holding is refused
      op(`FXU_MIN_SGL, 3'h0, fxu_pkg::FXU_K_MEM, fxu_pkg::FXU_P_SGL, 2'h2);
      chk("refused start", ov & 8'hf1, 8'h01);
      @(posedge clk_i);
      next_fp_i <= 1'b1;
      @(posedge clk_i);
      next_fp_i <= 1'b0;
      @(negedge clk_i);
      ov = {dest_we_o, dest_undef_o, dest_zero_o, exc_req_o, exc_post_o, exc_underflow_flag_o, exc_overflow_flag_o, busy_o};
      chk("pre report", ov, 8'h14);
      @(negedge clk_i);
      chk("single report", {31'h0, exc_req_o}, 32'h0);
      clr();
      $display("test pre report done");
   endtask : t_pre_report

   task automatic t_int_zero;
      op(`FXU_MIN_EXT - 17'h1, 3'h1, fxu_pkg::FXU_K_INT, fxu_pkg::FXU_P_EXT, 2'h0);
      chk("int zero", ov & 8'hf1, 8'ha0);
      rd(`FXU_OFF_STATUS);
      chk("int status", rv, 32'h0);
      $display("test integer done");
   endtask : t_int_zero

   task automatic t_dep_overflow_flag;
      wr(`FXU_OFF_CTRL, 32'h2);
      op(`FXU_MAX_DBL - 17'h1, 3'h0, fxu_pkg::FXU_K_FPREG, fxu_pkg::FXU_P_EXT, 2'h1);
      chk("below max", ov & 8'hf1, 8'h80);
      op(`FXU_MAX_DBL - 17'h1, 3'h4, fxu_pkg::FXU_K_FPREG, fxu_pkg::FXU_P_EXT, 2'h1);
      chk("dep overflow_flag", ov, 8'h1a);
      rd(`FXU_OFF_STATUS);
      chk("overflow_flag status", rv, 32'h840);
      rd(`FXU_OFF_FRAME);
      chk("dep frame", rv, 32'h16);
      wr(`FXU_OFF_CTRL, 32'h0);
      clr();
      $display("test dependent overflow done");
   endtask : t_dep_overflow_flag

   task automatic t_wrap_forced;
      op(17'h0, 3'h2, fxu_pkg::FXU_K_MEM, fxu_pkg::FXU_P_DBL, 2'h2);
      chk("wrap outputs", ov, 8'hda);
      rd(`FXU_OFF_FRAME);
      chk("wrap frame", rv, 32'h0e);
      clr();
      forced_i <= 1'b1;
      op_prec_i <= fxu_pkg::FXU_P_SGL;
      op(`FXU_MIN_SGL, 3'h0, fxu_pkg::FXU_K_FPREG, fxu_pkg::FXU_P_EXT, 2'h1);
      chk("forced underflow_flag", ov, 8'h1c);
      rd(`FXU_OFF_STATUS);
      chk("forced status", rv, 32'h400);
      forced_i <= 1'b0;
      clr();
      $display("test wrap and forced done");
   endtask : t_wrap_forced

   // clock enable low in mid-operation, then a reset in mid-run
   task automatic t_freeze_reset;
      @(posedge clk_i);
      start_i <= 1'b1;
      exp_i <= `FXU_MIN_SGL;
      {rnd_inc_i, exp_wrap_i, inex_i} <= 3'h1;
      kind_i <= fxu_pkg::FXU_K_MEM;
      fmt_i <= fxu_pkg::FXU_P_SGL;
      {move_out_i, dep_move_i} <= 2'h2;
      @(posedge clk_i);
      start_i <= 1'b0;
      ce_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      chk("frozen", {29'h0, dest_we_o, exc_req_o, busy_o}, 32'h1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      ov = {dest_we_o, dest_undef_o, dest_zero_o, exc_req_o, exc_post_o, exc_underflow_flag_o, exc_overflow_flag_o, busy_o};
      chk("thawed underflow_flag", ov, 8'hdc);
      rd(`FXU_OFF_STATUS);
      chk("thawed status", rv, 32'h420);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      ov = {dest_we_o, dest_undef_o, dest_zero_o, exc_req_o, exc_post_o, exc_underflow_flag_o, exc_overflow_flag_o, busy_o};
      chk("reset outputs", ov, 8'h00);
      rd(`FXU_OFF_STATUS);
      chk("reset status", rv, 32'h0);
      rd(`FXU_OFF_FRAME);
      chk("reset frame", rv, 32'h0);
      $display("test freeze and reset done");
   endtask : t_freeze_reset

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // hang guard, far beyond the couple of hundred cycles the run needs
   initial begin
      #1000000;
      mismatches++;
      final_report();
   end

   initial begin
      mismatches = 0;
      n_tests = 0;
      {rst_i, ce_i} = 2'h3;
      {start_i, rnd_inc_i, exp_wrap_i, inex_i, forced_i, move_out_i, dep_move_i, next_fp_i, we_i, re_i} = 10'h0;
      exp_i = 17'h0;
      kind_i = fxu_pkg::FXU_K_FPREG;
      fmt_i = fxu_pkg::FXU_P_EXT;
      op_prec_i = fxu_pkg::FXU_P_EXT;
      op_addr_i = 32'h00001000;
      ea_i = 32'h0000a5a0;
      addr_i = 8'h0;
      wdata_i = 32'h0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_mem_underflow_flag();
      t_pre_report();
      t_int_zero();
      t_dep_overflow_flag();
      t_wrap_forced();
      t_freeze_reset();
      final_report();
   end
endmodule : fxu_exc_unit_test
